// ==== dagc_map.svh ====
// Register offsets, field positions, reset values and timing counts of the gain controller
`ifndef DAGC_MAP_SVH
`define DAGC_MAP_SVH
`define DAGC_OFF_CTRL 8'h00
`define DAGC_OFF_CORR 8'h04
`define DAGC_OFF_PMF 8'h08
`define DAGC_OFF_THOFF 8'h0C
`define DAGC_OFF_THR 8'h10
`define DAGC_OFF_HYS 8'h14
`define DAGC_OFF_IF_ATTENUATION 8'h18
`define DAGC_OFF_STAT 8'h1C
`define DAGC_MASK_CTRL 32'h0000_FF07
`define DAGC_MASK_CORR 32'h00FF_07FF
`define DAGC_MASK_PMF 32'h0000_0F0F
`define DAGC_MASK_THOFF 32'h0000_0FFF
`define DAGC_MASK_THR 32'h0FFF_0FFF
`define DAGC_MASK_HYS 32'h01FF_0FFF
`define DAGC_MASK_IF_ATTENUATION 32'h0000_000F
`define DAGC_RST_CTRL 32'h0000_0005
`define DAGC_RST_CORR 32'h0040_0000
`define DAGC_RST_PMF 32'h0000_0404
`define DAGC_RST_THOFF 32'h0000_027F
`define DAGC_RST_THR 32'h0100_0080
`define DAGC_RST_HYS 32'h009B_00D5
`define DAGC_RST_IF_ATTENUATION 32'h0000_0000
`define DAGC_BIT_DDC 2
`define DAGC_POS_DELAY 8
`define DAGC_POS_SLOPE 16
`define DAGC_POS_DECAY 8
`define DAGC_POS_UPPER 16
`define DAGC_POS_DGC 16
`define DAGC_POS_LATE 4
`define DAGC_POS_LEVEL 16
`define DAGC_SDC_ATT_MAX 4'h9
`define DAGC_SLOPE_FRAC 6
`define DAGC_CLK_HZ 50000000
`define DAGC_SAMPLE_HZ 274000
`define DAGC_SAMPLE_CYC (`DAGC_CLK_HZ / `DAGC_SAMPLE_HZ)
`endif

// ==== dagc_pkg.sv ====
// Types shared by the gain controller
package dagc_pkg;
   typedef enum logic [1:0] {
      DAGC_MODE_OFF = 2'h0,
      DAGC_MODE_ALWAYS = 2'h1,
      DAGC_MODE_START = 2'h2,
      DAGC_MODE_FREEZE = 2'h3
   } dagc_mode_t;
   typedef enum logic [1:0] {
      DAGC_ST_IDLE = 2'h0,
      DAGC_ST_WAIT = 2'h1,
      DAGC_ST_RUN = 2'h3,
      DAGC_ST_HOLD = 2'h2
   } dagc_run_t;
endpackage

// ==== dagc_top.sv ====
// Digital gain controller: strength correction, peak memory filter, threshold gain steps
`timescale 1ns/1ps
`default_nettype none
`include "dagc_map.svh"

// Contract
// R1 - Each strength sample gets offset added, then is scaled by the slope factor.
// R2 - Peak memory integrator rises with attack gain, otherwise falls with decay gain.
// R3 - Software picks decay time much longer than attack time to ignore keying.
// R4 - Filtered level feeds two hysteretic comparators at lower and upper thresholds.
// R5 - One hysteresis value sets the release point of both comparators.
// R6 - Comparators select analog gain step and matching digital gain correction.
// R7 - Second IF gain is always exactly one of three levels.
// R8 - Gain step sits after second polyphase network or before second mixer.
// R9 - Filter difference signal is the delog table lookup input.
// R10 - First IF buffer attenuation is a manual 4-bit field, smaller range single-mode.
// R11 - Thresholds are dB above zero input via threshold offset, default 63.9 dB.
// R12 - Switching points are offset plus lower (12.8 dB) or upper (25.6 dB).
// R13 - Gain returns to maximum below lower point minus hysteresis (21.3 dB).
// R14 - Software is advised 15.5 dB correction and 21.3 dB hysteresis.
// R15 - Samples arrive at 274 kHz; gain g gives time constant 1/(g*274k).
// R16 - Start and freeze of gain control are programmable around signal identification.
// R17 - After reset: maximum gain, zero correction, cleared integrator.
module dagc_top #(
   parameter int SAMPLE_W = 10
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [SAMPLE_W-1:0] rssi_sample_i,
   input wire logic rssi_strobe_i,
   input wire logic sig_ident_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output dagc_pkg::dagc_run_t agc_run_o,
   output logic [1:0] if_gain_step_o,
   output logic [9:0] digital_gain_correction_o,
   output logic gain_at_mixer_o,
   output logic [3:0] first_if_buffer_o,
   output logic [12:0] delog_error_o,
   output logic delog_valid_o
);
   import dagc_pkg::*;

   if (SAMPLE_W < 4 || SAMPLE_W > 11)
   begin : g_bad_width
      $error("SAMPLE_W must lie in 4..11");
   end

   typedef struct packed {
      logic [SAMPLE_W-1:0] raw_m;
      logic [SAMPLE_W-1:0] raw_s;
      logic stb_m;
      logic stb_s;
      logic stb_d;
      logic [31:0] ctrl;
      logic [31:0] corr;
      logic [31:0] peak_memory_filter;
      logic [31:0] thoff;
      logic [31:0] thr;
      logic [31:0] hys;
      logic [31:0] if_attenuation;
      logic aw_hold;
      logic w_hold;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [11:0] corr_lvl;
      logic pend;
      logic [19:0] integ;
      logic cmp_lo;
      logic cmp_up;
      dagc_run_t run;
      logic [7:0] dly;
      logic [8:0] gap;
      logic late;
      logic [1:0] gain;
      logic [9:0] dgc_out;
      logic [12:0] err;
      logic err_vld;
      logic mixer;
      logic [3:0] ifbuf;
   } dagc_state_t;

   dagc_state_t state_ff;
   dagc_state_t nxt_state;

   function automatic logic [11:0] corr_fn(input logic [SAMPLE_W-1:0] raw,
                                           input logic [31:0] c);
      logic signed [12:0] sum;
      logic signed [21:0] prod;
      logic signed [15:0] sc;
      sum = $signed({{(13-SAMPLE_W){1'b0}}, raw}) + $signed({{2{c[10]}}, c[10:0]});
      prod = sum * $signed({1'b0, c[`DAGC_POS_SLOPE+:8]});
      sc = prod[`DAGC_SLOPE_FRAC+:16];
      if (sc < 16'sh0000)
         corr_fn = 12'h000;
      else if (sc > 16'sh0FFF)
         corr_fn = 12'hFFF;
      else
         corr_fn = sc[11:0];
   endfunction

   function automatic logic [9:0] dgc_fn(input logic [1:0] g, input logic [31:0] h);
      dgc_fn = {8'h00, g} * {1'b0, h[`DAGC_POS_DGC+:9]};
   endfunction

   function automatic logic [31:0] strb_fn(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s, input logic [31:0] m);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            v[8*i+:8] = d[8*i+:8];
      end
      strb_fn = v & m;
   endfunction

   dagc_mode_t mode;
   logic tick;
   logic active;
   logic go;
   logic [12:0] lvl13;
   logic [11:0] lvl_in;
   logic signed [20:0] err;
   logic [4:0] sh;
   logic signed [21:0] acc;
   logic [11:0] lvl_new;
   logic [12:0] lo_sw;
   logic [12:0] up_sw;
   logic signed [13:0] lo_rel;
   logic signed [13:0] up_rel;
   logic [31:0] rd;
   logic ctrl_wr;

   assign mode = dagc_mode_t'(state_ff.ctrl[1:0]);
   assign tick = state_ff.stb_s && !state_ff.stb_d;
   assign active = state_ff.run == DAGC_ST_RUN ||
                   (state_ff.run == DAGC_ST_WAIT && mode == DAGC_MODE_FREEZE);
   assign go = state_ff.pend && active && ce_i;

   always_comb
   begin
      rd = 32'h0000_0000;
      case (s_axi_araddr_i[7:2])
         6'h00: rd = state_ff.ctrl;
         6'h01: rd = state_ff.corr;
         6'h02: rd = state_ff.peak_memory_filter;
         6'h03: rd = state_ff.thoff;
         6'h04: rd = state_ff.thr;
         6'h05: rd = state_ff.hys;
         6'h06: rd = state_ff.if_attenuation;
         6'h07:
         begin
            rd[1:0] = state_ff.gain;
            rd[3:2] = state_ff.run;
            rd[`DAGC_POS_LATE] = state_ff.late;
            rd[`DAGC_POS_LEVEL+:12] = state_ff.integ[19:8];
         end
         default: rd = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.raw_m = rssi_sample_i;
      nxt_state.raw_s = state_ff.raw_m;
      nxt_state.stb_m = rssi_strobe_i;
      nxt_state.stb_s = state_ff.stb_m;
      nxt_state.stb_d = state_ff.stb_s;
      nxt_state.pend = 1'b0;
      nxt_state.err_vld = 1'b0;
      ctrl_wr = 1'b0;

      // Bus writes: address and data taken in either order
      if (s_axi_awvalid_i && state_ff.awready)
      begin
         nxt_state.aw_hold = 1'b1;
         nxt_state.waddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && state_ff.wready)
      begin
         nxt_state.w_hold = 1'b1;
         nxt_state.wdata = s_axi_wdata_i;
         nxt_state.wstrb = s_axi_wstrb_i;
      end
      if (state_ff.bvalid && s_axi_bready_i)
         nxt_state.bvalid = 1'b0;
      if (state_ff.aw_hold && state_ff.w_hold && !state_ff.bvalid)
      begin
         nxt_state.aw_hold = 1'b0;
         nxt_state.w_hold = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = 2'h0;
         case (state_ff.waddr[7:2])
            6'h00:
            begin
               nxt_state.ctrl = strb_fn(state_ff.ctrl, state_ff.wdata, state_ff.wstrb,
                                        `DAGC_MASK_CTRL);
               ctrl_wr = 1'b1;
            end
            6'h01: nxt_state.corr = strb_fn(state_ff.corr, state_ff.wdata, state_ff.wstrb,
                                            `DAGC_MASK_CORR);
            6'h02: nxt_state.peak_memory_filter = strb_fn(state_ff.peak_memory_filter, state_ff.wdata, state_ff.wstrb,
                                           `DAGC_MASK_PMF);
            6'h03: nxt_state.thoff = strb_fn(state_ff.thoff, state_ff.wdata, state_ff.wstrb,
                                             `DAGC_MASK_THOFF);
            6'h04: nxt_state.thr = strb_fn(state_ff.thr, state_ff.wdata, state_ff.wstrb,
                                           `DAGC_MASK_THR);
            6'h05: nxt_state.hys = strb_fn(state_ff.hys, state_ff.wdata, state_ff.wstrb,
                                           `DAGC_MASK_HYS);
            6'h06: nxt_state.if_attenuation = strb_fn(state_ff.if_attenuation, state_ff.wdata, state_ff.wstrb,
                                             `DAGC_MASK_IF_ATTENUATION);
            6'h07: nxt_state.bresp = 2'h0;
            default: nxt_state.bresp = 2'h2;
         endcase
      end
      nxt_state.awready = !nxt_state.aw_hold && !nxt_state.bvalid;
      nxt_state.wready = !nxt_state.w_hold && !nxt_state.bvalid;

      if (state_ff.rvalid && s_axi_rready_i)
         nxt_state.rvalid = 1'b0;
      if (s_axi_arvalid_i && state_ff.arready)
      begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = rd;
         nxt_state.rresp = (s_axi_araddr_i[7:5] == 3'h0) ? 2'h0 : 2'h2;
      end
      nxt_state.arready = !nxt_state.rvalid;

      // Sample gap watchdog; one sample per strobe edge at the fixed rate
      if (tick)
      begin
         nxt_state.gap = 9'h000;
         nxt_state.late = 1'b0;
         nxt_state.corr_lvl = corr_fn(state_ff.raw_s, state_ff.corr); // R1
         nxt_state.pend = 1'b1;
      end
      else if (state_ff.gap < 9'(2 * `DAGC_SAMPLE_CYC))
         nxt_state.gap = state_ff.gap + 9'h001;
      else
         nxt_state.late = 1'b1;

      // Gain-compensated level so the loop sees the antenna level, not the stepped one
      lvl13 = {1'b0, state_ff.corr_lvl} + {3'h0, state_ff.dgc_out};
      lvl_in = (lvl13 > 13'h0FFF) ? 12'hFFF : lvl13[11:0];
      err = $signed({1'b0, lvl_in, 8'h00}) - $signed({1'b0, state_ff.integ});
      // Shift is the integrator gain 2^-n per 274 kHz sample; decay on top of attack
      sh = (err > 21'sh0) ? {1'b0, state_ff.peak_memory_filter[3:0]} // R2 R15
                          : {1'b0, state_ff.peak_memory_filter[3:0]} + {1'b0, state_ff.peak_memory_filter[`DAGC_POS_DECAY+:4]};
      acc = $signed({2'h0, state_ff.integ}) + 22'(err >>> sh);
      if (acc < 22'sh0)
         lvl_new = 12'h000;
      else
         lvl_new = acc[19:8];
      lo_sw = {1'b0, state_ff.thoff[11:0]} + {1'b0, state_ff.thr[11:0]}; // R11 R12
      up_sw = {1'b0, state_ff.thoff[11:0]} + {1'b0, state_ff.thr[`DAGC_POS_UPPER+:12]};
      lo_rel = $signed({1'b0, lo_sw}) - $signed({2'h0, state_ff.hys[11:0]}); // R5 R13
      up_rel = $signed({1'b0, up_sw}) - $signed({2'h0, state_ff.hys[11:0]}); // R5

      if (state_ff.pend && active)
      begin
         nxt_state.integ = (acc < 22'sh0) ? 20'h00000 : acc[19:0]; // R2
         nxt_state.err = err[20:8]; // R9
         nxt_state.err_vld = 1'b1;
         if ({1'b0, lvl_new} >= lo_sw) // R4
            nxt_state.cmp_lo = 1'b1;
         else if ($signed({2'h0, lvl_new}) < lo_rel) // R13
            nxt_state.cmp_lo = 1'b0;
         if ({1'b0, lvl_new} >= up_sw) // R4
            nxt_state.cmp_up = 1'b1;
         else if ($signed({2'h0, lvl_new}) < up_rel)
            nxt_state.cmp_up = 1'b0;
      end

      case (state_ff.run) // R16
         DAGC_ST_IDLE:
            if (mode == DAGC_MODE_ALWAYS || mode == DAGC_MODE_FREEZE)
               nxt_state.run = DAGC_ST_RUN;
            else if (mode == DAGC_MODE_START && sig_ident_i)
            begin
               nxt_state.run = DAGC_ST_WAIT;
               nxt_state.dly = state_ff.ctrl[`DAGC_POS_DELAY+:8];
            end
         DAGC_ST_WAIT:
            if (tick)
            begin
               if (state_ff.dly != 8'h00)
                  nxt_state.dly = state_ff.dly - 8'h01;
               else
                  nxt_state.run = (mode == DAGC_MODE_START) ? DAGC_ST_RUN : DAGC_ST_HOLD;
            end
         DAGC_ST_RUN:
            if (mode == DAGC_MODE_FREEZE && sig_ident_i)
            begin
               nxt_state.run = DAGC_ST_WAIT;
               nxt_state.dly = state_ff.ctrl[`DAGC_POS_DELAY+:8];
            end
         DAGC_ST_HOLD: nxt_state.run = DAGC_ST_HOLD;
         default: nxt_state.run = DAGC_ST_IDLE;
      endcase
      // Applied after the sequencer so a held loop can be restarted
      if (ctrl_wr)
         nxt_state.run = DAGC_ST_IDLE; // R16
      // Off forces maximum gain; a frozen loop simply keeps its last step
      if (mode == DAGC_MODE_OFF)
      begin
         nxt_state.run = DAGC_ST_IDLE;
         nxt_state.cmp_lo = 1'b0;
         nxt_state.cmp_up = 1'b0;
      end

      nxt_state.gain = {1'b0, nxt_state.cmp_lo} + {1'b0, nxt_state.cmp_up}; // R6 R7
      nxt_state.dgc_out = dgc_fn(nxt_state.gain, nxt_state.hys); // R6
      nxt_state.mixer = nxt_state.ctrl[`DAGC_BIT_DDC]; // R8
      if (!nxt_state.ctrl[`DAGC_BIT_DDC] && nxt_state.if_attenuation[3:0] > `DAGC_SDC_ATT_MAX)
         nxt_state.ifbuf = `DAGC_SDC_ATT_MAX; // R10
      else
         nxt_state.ifbuf = nxt_state.if_attenuation[3:0]; // R10
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_ff <= '0; // R17
         state_ff.ctrl <= `DAGC_RST_CTRL;
         state_ff.corr <= `DAGC_RST_CORR;
         state_ff.peak_memory_filter <= `DAGC_RST_PMF;
         state_ff.thoff <= `DAGC_RST_THOFF;
         state_ff.thr <= `DAGC_RST_THR;
         state_ff.hys <= `DAGC_RST_HYS; // R14
         state_ff.if_attenuation <= `DAGC_RST_IF_ATTENUATION;
         state_ff.mixer <= 1'b1;
      end
      else if (ce_i)
      begin
         state_ff <= nxt_state;
      end
   end

   assign s_axi_awready_o = state_ff.awready;
   assign s_axi_wready_o = state_ff.wready;
   assign s_axi_bvalid_o = state_ff.bvalid;
   assign s_axi_bresp_o = state_ff.bresp;
   assign s_axi_arready_o = state_ff.arready;
   assign s_axi_rvalid_o = state_ff.rvalid;
   assign s_axi_rresp_o = state_ff.rresp;
   assign s_axi_rdata_o = state_ff.rdata;
   assign agc_run_o = state_ff.run;
   assign if_gain_step_o = state_ff.gain;
   assign digital_gain_correction_o = state_ff.dgc_out;
   assign gain_at_mixer_o = state_ff.mixer;
   assign first_if_buffer_o = state_ff.ifbuf;
   assign delog_error_o = state_ff.err;
   assign delog_valid_o = state_ff.err_vld;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_corr;
      tick && ce_i |=> state_ff.corr_lvl == corr_fn($past(state_ff.raw_s), $past(state_ff.corr));
   endproperty
   a_corr: assert property (p_corr) else $error("corrected sample mismatch"); // R1

   property p_attack;
      go && err > 21'sh0 |=> state_ff.integ >= $past(state_ff.integ) && state_ff.err_vld;
   endproperty
   a_attack: assert property (p_attack) else $error("integrator fell on attack"); // R2

   property p_decay;
      go && err < 21'sh0 |=> state_ff.integ <= $past(state_ff.integ);
   endproperty
   a_decay: assert property (p_decay) else $error("integrator rose on decay"); // R2

   property p_upper;
      go && mode != DAGC_MODE_OFF && {1'b0, lvl_new} >= up_sw
         |=> state_ff.cmp_up && if_gain_step_o != 2'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper point missed"); // R4

   property p_release;
      go && $signed({2'h0, lvl_new}) < lo_rel && $signed({2'h0, lvl_new}) < up_rel
         |=> if_gain_step_o == 2'h0;
   endproperty
   a_release: assert property (p_release) else $error("no return to maximum gain"); // R13

   property p_three;
      if_gain_step_o != 2'h3
         && if_gain_step_o == {1'b0, state_ff.cmp_lo} + {1'b0, state_ff.cmp_up};
   endproperty
   a_three: assert property (p_three) else $error("illegal gain step"); // R7

   property p_dgc;
      digital_gain_correction_o == dgc_fn(if_gain_step_o, state_ff.hys);
   endproperty
   a_dgc: assert property (p_dgc) else $error("digital correction mismatch"); // R6

   property p_mixer;
      gain_at_mixer_o == state_ff.ctrl[`DAGC_BIT_DDC];
   endproperty
   a_mixer: assert property (p_mixer) else $error("gain step position wrong"); // R8

   property p_if_attenuation;
      !gain_at_mixer_o |-> first_if_buffer_o <= `DAGC_SDC_ATT_MAX;
   endproperty
   a_if_attenuation: assert property (p_if_attenuation) else $error("single-mode attenuation too large"); // R10

   property p_reset;
      $past(rst_i) |-> if_gain_step_o == 2'h0 && digital_gain_correction_o == 10'h000
         && state_ff.integ == 20'h00000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong"); // R17

   property p_frozen;
      ce_i && state_ff.run == DAGC_ST_HOLD |=> $stable(state_ff.integ) && $stable(if_gain_step_o);
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen loop moved"); // R16

   c_max_att: cover property (if_gain_step_o == 2'h2);
   c_freeze: cover property (state_ff.run == DAGC_ST_WAIT ##1 state_ff.run == DAGC_ST_HOLD);
   c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
   c_back: cover property (if_gain_step_o == 2'h1 ##[1:300] if_gain_step_o == 2'h0);
endmodule // dagc_top
`default_nettype wire

// ==== dagc_adc_model.sv ====
// Behavioural RSSI converter and analog second IF gain stage facing the gain controller
`timescale 1ns/1ps
`default_nettype none
`include "dagc_map.svh"
module dagc_adc_model #(
   parameter int STEP_DROP = 155
) (
   input wire logic clk_sys_i,
   input wire logic [1:0] if_gain_step_i,
   input wire logic [12:0] strength_i,
   output logic [9:0] rssi_sample_o,
   output logic rssi_strobe_o
);
   int cnt_ff;
   int lvl;
   initial
   begin
      cnt_ff = 0;
      rssi_sample_o = 10'h000;
      rssi_strobe_o = 1'b0;
   end
   // Sample settles well before the strobe so the two-stage sync sees it stable
   always @(posedge clk_sys_i)
   begin
      cnt_ff <= (cnt_ff == `DAGC_SAMPLE_CYC - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == 0)
      begin
         // Reduced IF gain lowers what the converter sees
         lvl = int'(strength_i) - int'(if_gain_step_i) * STEP_DROP;
         rssi_sample_o <= (lvl < 0) ? 10'h000 : (lvl > 1023) ? 10'h3FF : 10'(lvl);
      end
      rssi_strobe_o <= (cnt_ff >= 3) && (cnt_ff < 7);
   end
endmodule // dagc_adc_model
`default_nettype wire

// ==== dagc_top_tb.sv ====
// Self-checking bench for the gain controller
`timescale 1ns/1ps
`default_nettype none
`include "dagc_map.svh"
module dagc_top_tb;
   import dagc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} dagc_row_t;
   logic clk = 1'b0, rst = 1'b1, ident = 1'b0, ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, strobe, mixer, dvalid;
   logic [1:0] bresp, rresp, step, resp;
   logic [31:0] rd;
   logic [9:0] sample, corr;
   logic [3:0] ifbuf;
   logic [12:0] derr, strength = 13'h0, last_err = 13'h0;
   dagc_run_t run;
   int n_fail = 0, tests_run = 0, n_dv = 0;
   dagc_row_t rows [9] = '{
      '{8'h00, `DAGC_RST_CTRL, 2'h0}, '{8'h04, `DAGC_RST_CORR, 2'h0},
      '{8'h08, `DAGC_RST_PMF, 2'h0}, '{8'h0C, 32'h0000_027F, 2'h0},
      '{8'h10, 32'h0100_0080, 2'h0}, '{8'h14, 32'h009B_00D5, 2'h0},
      '{8'h18, `DAGC_RST_IF_ATTENUATION, 2'h0}, '{8'h1C, 32'h0000_000C, 2'h0},
      '{8'h20, 32'h0000_0000, 2'h2}};
   always #10 clk = ~clk;
   dagc_adc_model u_dagc_adc_model (.clk_sys_i(clk), .if_gain_step_i(step),
      .strength_i(strength), .rssi_sample_o(sample), .rssi_strobe_o(strobe));
   dagc_top u_dagc_top (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .rssi_sample_i(sample),
      .rssi_strobe_i(strobe), .sig_ident_i(ident), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .agc_run_o(run), .if_gain_step_o(step),
      .digital_gain_correction_o(corr), .gain_at_mixer_o(mixer),
      .first_if_buffer_o(ifbuf), .delog_error_o(derr), .delog_valid_o(dvalid));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      forever
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic hold(input int n);
      repeat (n * `DAGC_SAMPLE_CYC) @(posedge clk);
   endtask
   // Bounded wait for a gain step; the compare after it reports a miss
   task automatic wait_step(input logic [1:0] g);
      for (int i = 0; i < 20000 && step !== g; i++) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      if (!rst && step !== 2'h0 && step !== 2'h1 && step !== 2'h2)
         chk("gain step", 32'h0, 32'(step));
      if (dvalid === 1'b1)
      begin
         n_dv++;
         last_err = derr;
      end
   end
   initial
   begin
      // About twice the expected length of all tests
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("unexpected watchdog: expected end seen timeout");
      print_verdict();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("gain", 32'h0, 32'(step));
      chk("correction", 32'h0, 32'(corr));
      chk("mixer", 32'h1, 32'(mixer));
      foreach (rows[i])
      begin
         axi_rd(rows[i].a);
         chk("read data", rows[i].d, rd);
         chk("read resp", 32'(rows[i].r), 32'(resp));
      end
      $display("test reset values done");
      axi_wr(8'h18, 32'h0000_000F);
      @(posedge clk);
      chk("buffer ddc", 32'hF, 32'(ifbuf));
      axi_wr(8'h00, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("buffer sdc", 32'h9, 32'(ifbuf));
      chk("mixer sdc", 32'h0, 32'(mixer));
      axi_wr(8'h24, 32'h0000_0001);
      chk("unmapped write", 32'h2, 32'(resp));
      axi_wr(8'h1C, 32'hFFFF_FFFF);
      chk("status write", 32'h0, 32'(resp));
      $display("test buffer and bus done");
      // Fast decay keeps the run short; attack still no slower than decay
      axi_wr(8'h08, 32'h0000_0004);
      axi_wr(8'h14, 32'h009B_00D5);
      axi_wr(8'h04, 32'h0040_060C);
      axi_wr(8'h00, 32'h0000_0005);
      strength <= 13'd1300;
      hold(40);
      chk("gain offset", 32'h0, 32'(step));
      $display("test offset done");
      axi_wr(8'h04, 32'h0040_0000);
      axi_wr(8'h00, 32'h0000_0006);
      hold(30);
      chk("gain before event", 32'h0, 32'(step));
      chk("run before event", 32'h0, 32'(run));
      @(posedge clk);
      ident <= 1'b1;
      @(posedge clk);
      ident <= 1'b0;
      n_dv = 0;
      wait_step(2'h2);
      chk("gain strong", 32'h2, 32'(step));
      chk("correction strong", 32'd310, 32'(corr));
      chk("run started", 32'h3, 32'(run));
      chk("delog active", 32'h1, 32'(n_dv > 0));
      chk("delog sign attack", 32'h0, 32'(last_err[12]));
      $display("test attack done");
      // Enable low must hold the step although the level has dropped
      @(posedge clk);
      ce <= 1'b0;
      strength <= 13'd0;
      hold(20);
      chk("gain with enable low", 32'h2, 32'(step));
      ce <= 1'b1;
      wait_step(2'h0);
      chk("gain weak", 32'h0, 32'(step));
      chk("correction weak", 32'h0, 32'(corr));
      chk("delog sign decay", 32'h1, 32'(last_err[12]));
      $display("test decay done");
      // Freeze on event with two samples of delay, then restart by a control write
      axi_wr(8'h00, 32'h0000_0207);
      @(posedge clk);
      ident <= 1'b1;
      @(posedge clk);
      ident <= 1'b0;
      hold(5);
      strength <= 13'd1300;
      hold(20);
      chk("gain frozen", 32'h0, 32'(step));
      chk("run frozen", 32'h2, 32'(run));
      axi_wr(8'h00, 32'h0000_0005);
      wait_step(2'h2);
      chk("gain after restart", 32'h2, 32'(step));
      $display("test freeze done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("gain after reset", 32'h0, 32'(step));
      chk("correction after reset", 32'h0, 32'(corr));
      axi_rd(8'h00);
      chk("control after reset", `DAGC_RST_CTRL, rd);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule // dagc_top_tb
`default_nettype wire
